// file: shared/ais_consts.vh
/*
  Constants for the converter input-select block: register offset,
  field positions, reset value and multiplexer select codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef AIS_CONSTS_VH
`define AIS_CONSTS_VH

// ==========================================================
// Register map
`define AIS_SEL_OFFSET 4'h0
`define AIS_SEL_RESET 16'h0000
`define AIS_BUS_OKAY 2'h0
`define AIS_BUS_SLVERR 2'h2

// ==========================================================
// Field positions
`define AIS_B_NEG_HI 15
`define AIS_B_NEG_LO 13
`define AIS_B_POS_HI 12
`define AIS_B_POS_LO 8
`define AIS_A_NEG_HI 7
`define AIS_A_NEG_LO 5
`define AIS_A_POS_HI 4
`define AIS_A_POS_LO 0

// ==========================================================
// Negative input codes
`define AIS_NEG_VREF 3'h0
`define AIS_NEG_AN1 3'h2

// ==========================================================
// Positive input codes
`define AIS_POS_EXT_MAX 5'h0F
`define AIS_POS_HI_FIRST 5'h10
`define AIS_POS_HI_LAST 5'h17
`define AIS_POS_TEMP 5'h18
`define AIS_POS_MEAS 5'h19
`define AIS_POS_RSV0 5'h1A
`define AIS_POS_RSV1 5'h1B
`define AIS_POS_BANDGAP 5'h1C
`define AIS_POS_AGND 5'h1D
`define AIS_POS_ASUP 5'h1E
`define AIS_POS_HALFBAT 5'h1F

// ==========================================================
// Internal source one-hot bits
`define AIS_INT_BANDGAP 0
`define AIS_INT_AGND 1
`define AIS_INT_ASUP 2
`define AIS_INT_HALFBAT 3
`define AIS_INT_TEMP 4
`define AIS_INT_MEAS 5

`endif

// file: rtl/ais_pos_decode.v
/*
  Decoder for one five-bit positive-input select code into one-hot
  external and internal source enables.
  Assumes a registered code; output is purely combinational.
*/
`timescale 1ns/1ns
`include "ais_consts.vh"

module ais_pos_decode #(
  parameter SMALL_PKG = 0
)
(
  input wire [4:0] code,
  output reg [23:0] ext_sel,
  output reg [5:0] int_sel,
  output reg no_buffer
);
  always @*
  begin
    ext_sel = 24'h000000;
    int_sel = 6'h00;
    no_buffer = 1'b0;
    if (code <= `AIS_POS_EXT_MAX)
    begin
      ext_sel[code] = 1'b1; // R4
    end
    else if (code <= `AIS_POS_HI_LAST)
    begin
      // Upper inputs not bonded out on the small package
      if (SMALL_PKG == 0)
      begin
        ext_sel[code] = 1'b1; // R5
      end
    end
    else
    begin
      case (code)
        `AIS_POS_TEMP: int_sel[`AIS_INT_TEMP] = 1'b1; // R7 R8
        `AIS_POS_MEAS: int_sel[`AIS_INT_MEAS] = 1'b1; // R7
        `AIS_POS_BANDGAP:
        begin
          int_sel[`AIS_INT_BANDGAP] = 1'b1; // R6
          no_buffer = 1'b1;
        end
        `AIS_POS_AGND:
        begin
          int_sel[`AIS_INT_AGND] = 1'b1; // R6
          no_buffer = 1'b1;
        end
        `AIS_POS_ASUP:
        begin
          int_sel[`AIS_INT_ASUP] = 1'b1; // R6
          no_buffer = 1'b1;
        end
        `AIS_POS_HALFBAT:
        begin
          int_sel[`AIS_INT_HALFBAT] = 1'b1; // R6
          no_buffer = 1'b1;
        end
        default: int_sel = 6'h00; // R7
      endcase
    end
  end
endmodule // ais_pos_decode

// file: rtl/ais_input_select.v
/*
  Converter channel 0 input-select register behind an AXI4-Lite slave,
  with decoded multiplexer selects for sample sets A and B.
  Assumes one clock aclk and a synchronous active-low reset aresetn.
*/
// The implementer's own choices: the address map and the AXI4-Lite register port.
// Functional notes
// R1 - B negative: 000 reference, 010 input 1
// R2 - B positive field decodes shared table
// R3 - A positive field decodes same table
// R4 - Codes 0-15 route external inputs 0-15
// R5 - Codes 16-23 route inputs 16-23, package-dependent
// R6 - Codes 28-31 select internal sources, unbuffered
// R7 - 24 temp sensor, 25 meas unit, 26-27 none
// R8 - Temp sensor needs no meas-unit enable
// R9 - A negative decodes same as B negative
// R10 - Fields read/write, reset to zero
`timescale 1ns/1ns
`include "ais_consts.vh"

module ais_input_select #(
  parameter SMALL_PKG = 0
)
(
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [23:0] samp_a_ext_q,
  output reg [5:0] samp_a_int_q,
  output reg samp_a_nobuf_q,
  output reg samp_a_neg_vref_q,
  output reg samp_a_neg_an1_q,
  output reg [23:0] samp_b_ext_q,
  output reg [5:0] samp_b_int_q,
  output reg samp_b_nobuf_q,
  output reg samp_b_neg_vref_q,
  output reg samp_b_neg_an1_q
);
  // ========================================================
  // Register and bus state
  reg [15:0] sel_q;
  reg [15:0] sel_d;
  reg aw_got_q;
  reg w_got_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire aw_take;
  wire w_take;
  wire wr_go;
  wire [2:0] samp_b_neg_sel;
  wire [4:0] samp_b_pos_sel;
  wire [2:0] samp_a_neg_sel;
  wire [4:0] samp_a_pos_sel;
  wire [23:0] a_ext;
  wire [5:0] a_int;
  wire a_nobuf;
  wire [23:0] b_ext;
  wire [5:0] b_int;
  wire b_nobuf;

  assign samp_b_neg_sel = sel_q[`AIS_B_NEG_HI:`AIS_B_NEG_LO];
  assign samp_b_pos_sel = sel_q[`AIS_B_POS_HI:`AIS_B_POS_LO];
  assign samp_a_neg_sel = sel_q[`AIS_A_NEG_HI:`AIS_A_NEG_LO];
  assign samp_a_pos_sel = sel_q[`AIS_A_POS_HI:`AIS_A_POS_LO];

  // ========================================================
  // Write channel: address and data taken in either order
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
  assign wr_go = (aw_got_q | aw_take) & (w_got_q | w_take) &
                 ~s_axi_bvalid;

  always @*
  begin
    sel_d = sel_q;
    if (wr_go && {wr_addr[3:2], 2'h0} == `AIS_SEL_OFFSET)
    begin
      // Upper two lanes are outside the 16-bit register
      if (wr_strb[0])
        sel_d[7:0] = wr_data[7:0]; // R10
      if (wr_strb[1])
        sel_d[15:8] = wr_data[15:8]; // R10
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= `AIS_SEL_RESET; // R10
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AIS_BUS_OKAY;
    end
    else
    begin
      sel_q <= sel_d;
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ({wr_addr[3:2], 2'h0} == `AIS_SEL_OFFSET) ?
                       `AIS_BUS_OKAY : `AIS_BUS_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_got_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_take)
        begin
          w_got_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      // Ready only while nothing of that channel is held
      s_axi_awready <= ~aw_got_q & ~aw_take & ~wr_go & ~s_axi_bvalid;
      s_axi_wready <= ~w_got_q & ~w_take & ~wr_go & ~s_axi_bvalid;
    end
  end

  // ========================================================
  // Read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AIS_BUS_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if ({s_axi_araddr[3:2], 2'h0} == `AIS_SEL_OFFSET)
        begin
          s_axi_rdata <= {16'h0000, sel_q}; // R10
          s_axi_rresp <= `AIS_BUS_OKAY;
        end
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AIS_BUS_SLVERR;
        end
      end
      else if (s_axi_rvalid)
      begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b0;
      end
      else
        s_axi_arready <= 1'b1;
    end
  end

  // ========================================================
  // Input decoders
  ais_pos_decode #(.SMALL_PKG(SMALL_PKG)) u_dec_a (
    .code(samp_a_pos_sel), // R3
    .ext_sel(a_ext),
    .int_sel(a_int),
    .no_buffer(a_nobuf)
  );

  ais_pos_decode #(.SMALL_PKG(SMALL_PKG)) u_dec_b (
    .code(samp_b_pos_sel), // R2
    .ext_sel(b_ext),
    .int_sel(b_int),
    .no_buffer(b_nobuf)
  );

  // Registered so the analog switch drives never glitch
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      samp_a_ext_q <= 24'h000001;
      samp_a_int_q <= 6'h00;
      samp_a_nobuf_q <= 1'b0;
      samp_a_neg_vref_q <= 1'b1;
      samp_a_neg_an1_q <= 1'b0;
      samp_b_ext_q <= 24'h000001;
      samp_b_int_q <= 6'h00;
      samp_b_nobuf_q <= 1'b0;
      samp_b_neg_vref_q <= 1'b1;
      samp_b_neg_an1_q <= 1'b0;
    end
    else
    begin
      samp_a_ext_q <= a_ext;
      samp_a_int_q <= a_int;
      samp_a_nobuf_q <= a_nobuf;
      samp_a_neg_vref_q <= (samp_a_neg_sel == `AIS_NEG_VREF); // R9
      samp_a_neg_an1_q <= (samp_a_neg_sel == `AIS_NEG_AN1); // R9
      samp_b_ext_q <= b_ext;
      samp_b_int_q <= b_int;
      samp_b_nobuf_q <= b_nobuf;
      samp_b_neg_vref_q <= (samp_b_neg_sel == `AIS_NEG_VREF); // R1
      samp_b_neg_an1_q <= (samp_b_neg_sel == `AIS_NEG_AN1); // R1
    end
  end
endmodule // ais_input_select

// file: bench/ais_input_select_props.sv
/* Port assertions for the input-select block.
   Assumes one clock, reset synchronous and active low. */
`timescale 1ns/1ns
module ais_input_select_props (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [23:0] samp_a_ext_q,
  input wire [5:0] samp_a_int_q,
  input wire samp_a_nobuf_q,
  input wire samp_a_neg_vref_q,
  input wire samp_a_neg_an1_q,
  input wire [23:0] samp_b_ext_q,
  input wire samp_b_nobuf_q,
  input wire [5:0] samp_b_int_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ======
  // Selects
  a_ext_hot_a: assert property ($onehot0(samp_a_ext_q))
    else $error("sample A external select not one-hot");
  b_ext_hot_a: assert property ($onehot0(samp_b_ext_q))
    else $error("sample B external select not one-hot");
  a_src_excl_a: assert property (
    $onehot0({|samp_a_ext_q, samp_a_int_q}))
    else $error("sample A selects two sources");
  a_nobuf_a: assert property (
    samp_a_nobuf_q == (|samp_a_int_q[3:0]))
    else $error("sample A buffer flag wrong");
  b_nobuf_a: assert property (
    samp_b_nobuf_q == (|samp_b_int_q[3:0]))
    else $error("sample B buffer flag wrong");
  neg_excl_a: assert property (
    !(samp_a_neg_vref_q && samp_a_neg_an1_q))
    else $error("sample A negative selects both");
  reset_sel_a: assert property ($rose(aresetn) |->
    samp_a_ext_q == 24'h000001 && samp_a_neg_vref_q)
    else $error("reset select not input 0");
  // ======
  // Bus answers hold until taken
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (samp_a_int_q[4]);
endmodule // ais_input_select_props
bind ais_input_select ais_input_select_props u_props (.*);

// file: bench/ais_input_select_bench.sv
/* Bench for the input-select block.
   Drives the AXI4-Lite port itself; no far-side model. */
`timescale 1ns/1ns
`include "ais_consts.vh"
module ais_input_select_bench;
  logic aclk;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] samp_a_ext_q, samp_b_ext_q;
  wire [5:0] samp_a_int_q, samp_b_int_q;
  wire samp_a_nobuf_q, samp_a_neg_vref_q, samp_a_neg_an1_q;
  wire samp_b_nobuf_q, samp_b_neg_vref_q, samp_b_neg_an1_q;
  wire [23:0] sm_a_ext, sm_b_ext;
  logic [31:0] rd;
  logic [1:0] resp;
  int n_mismatch = 0;
  int num_checks = 0;
  ais_input_select uut (.*);
  // Small package copy: same bus traffic, only external selects watched
  ais_input_select #(.SMALL_PKG(1)) uut_small (
    .*,
    .s_axi_awready(),
    .s_axi_wready(),
    .s_axi_bresp(),
    .s_axi_bvalid(),
    .s_axi_arready(),
    .s_axi_rdata(),
    .s_axi_rresp(),
    .s_axi_rvalid(),
    .samp_a_ext_q(sm_a_ext),
    .samp_a_int_q(),
    .samp_a_nobuf_q(),
    .samp_a_neg_vref_q(),
    .samp_a_neg_an1_q(),
    .samp_b_ext_q(sm_b_ext),
    .samp_b_int_q(),
    .samp_b_nobuf_q(),
    .samp_b_neg_vref_q(),
    .samp_b_neg_an1_q()
  );
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ======
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input int lag = 0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    // Late acceptance: the response must stand until taken
    if (lag > 0)
    begin
      repeat (lag) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    chk(s_axi_bvalid, 32'h1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rdt(input logic [3:0] a, input int lag = 0);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    if (lag > 0)
    begin
      repeat (lag) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
    end
    chk(s_axi_rvalid, 32'h1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  function automatic logic [31:0] exp_pos(input logic [4:0] c);
    logic [5:0] i;
    i = 6'h0;
    if (c >= 5'h1C) i = 6'h01 << (c - 5'h1C);
    if (c == 5'h18) i = 6'h10;
    if (c == 5'h19) i = 6'h20;
    return {1'b0, c >= 5'h1C, i, c < 5'h18 ? 24'h1 << c : 24'h0};
  endfunction
  // ======
  // Scenarios
  task automatic t_reset;
    chk({samp_a_nobuf_q, samp_a_int_q, samp_a_ext_q}, 32'h1);
    chk({samp_b_neg_vref_q, samp_b_neg_an1_q}, 32'h2);
    rdt(`AIS_SEL_OFFSET);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_table;
    logic [2:0] na, nb;
    logic [4:0] pa, pb;
    for (int c = 0; c < 32; c++)
    begin
      pa = c[4:0];
      pb = ~pa;
      na = pa[2:0];
      nb = na + 3'h3;
      wr(`AIS_SEL_OFFSET, {16'h0, nb, pb, na, pa});
      chk(resp, `AIS_BUS_OKAY);
      // Decode lands one edge after the response; wait with margin
      repeat (3) @(posedge aclk);
      chk({samp_a_nobuf_q, samp_a_int_q, samp_a_ext_q}, exp_pos(pa));
      chk({samp_b_nobuf_q, samp_b_int_q, samp_b_ext_q}, exp_pos(pb));
      chk(sm_a_ext, pa < `AIS_POS_HI_FIRST ? 24'h1 << pa : 24'h0);
      chk(sm_b_ext, pb < `AIS_POS_HI_FIRST ? 24'h1 << pb : 24'h0);
      chk({samp_a_neg_vref_q, samp_a_neg_an1_q}, {na == 0, na == 2});
      chk({samp_b_neg_vref_q, samp_b_neg_an1_q}, {nb == 0, nb == 2});
      rdt(`AIS_SEL_OFFSET);
      chk(rd, {16'h0, nb, pb, na, pa});
    end
    $display("test table done");
  endtask
  task automatic t_unmapped;
    wr(4'h4, 32'h0000FFFF);
    chk(resp, `AIS_BUS_SLVERR);
    rdt(4'h4);
    chk(resp, `AIS_BUS_SLVERR);
    chk(rd, 32'h0);
    rdt(`AIS_SEL_OFFSET);
    chk(rd, 32'h000040FF);
    $display("test unmapped done");
  endtask
  task automatic t_slow;
    // Lane 1 only: upper byte changes, lower byte keeps 8'hFF
    s_axi_wstrb <= 4'h2;
    wr(`AIS_SEL_OFFSET, 32'hFFFFA5C3, 3);
    chk(resp, `AIS_BUS_OKAY);
    s_axi_wstrb <= 4'hF;
    rdt(`AIS_SEL_OFFSET, 3);
    chk(rd, 32'h0000A5FF);
    chk({samp_b_neg_vref_q, samp_b_neg_an1_q}, 32'h0);
    chk(samp_b_ext_q, 32'h20);
    $display("test slow done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #(100 * 5000);
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_table;
    t_unmapped;
    t_slow;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    stop_test;
  end
endmodule // ais_input_select_bench
